/* verilog/lprr_map.svh */
// register offsets, field positions, reset values and timing counts of the result register bank
`ifndef LPRR_MAP_SVH
`define LPRR_MAP_SVH

// ==========================================================
// register offsets (byte pointer values on the serial bus)
`define LPRR_ADDR_AMB_HI 8'h85
`define LPRR_ADDR_AMB_LO 8'h86
`define LPRR_ADDR_PROX_HI 8'h87
`define LPRR_ADDR_PROX_LO 8'h88
`define LPRR_ADDR_FREQ 8'h89

// ==========================================================
// frequency select field
`define LPRR_FREQ_MSB 1
`define LPRR_FREQ_LSB 0
`define LPRR_FREQ_RST 2'h2

// ==========================================================
// default 7-bit bus address of the sensor
`define LPRR_BUS_ADDR 7'h13

// ==========================================================
// timing: clock rate and infrared test signal rates, in hertz
`define LPRR_CLK_HZ 200000000
`define LPRR_IR_F0_HZ 3125000
`define LPRR_IR_F1_HZ 1562500
`define LPRR_IR_F2_HZ 781250
`define LPRR_IR_F3_HZ 390625
// half periods of the square wave in clock cycles
`define LPRR_IR_HALF0 (`LPRR_CLK_HZ / (2 * `LPRR_IR_F0_HZ))
`define LPRR_IR_HALF1 (`LPRR_CLK_HZ / (2 * `LPRR_IR_F1_HZ))
`define LPRR_IR_HALF2 (`LPRR_CLK_HZ / (2 * `LPRR_IR_F2_HZ))
`define LPRR_IR_HALF3 (`LPRR_CLK_HZ / (2 * `LPRR_IR_F3_HZ))

`endif

/* verilog/lprr_pkg.sv */
// types shared by the result register bank
`default_nettype none
package lprr_pkg;

  // ==========================================================
  // a finished measurement handed to the bank
  typedef struct packed {
    logic load;
    logic [15:0] value;
  } lprr_meas_type;

  // ==========================================================
  // serial slave states
  typedef enum logic [2:0] {
    LPRR_IDLE,
    LPRR_ADDR,
    LPRR_ACK,
    LPRR_WRX,
    LPRR_RDATA,
    LPRR_RACK
  } lprr_state_type;

endpackage : lprr_pkg
`default_nettype wire

/* verilog/lprr_ir_gen.sv */
// square-wave infrared test signal generator with selectable rate
`timescale 1ns/100ps
`default_nettype none
`include "lprr_map.svh"

module lprr_ir_gen #(
  parameter int CNT_W = 9
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic [1:0] sel,
  // square wave out
  output logic ir_out
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] limit;

  // ==========================================================
  // half-period limit per select code
  always_comb begin
    unique case (sel)
      2'h0: limit = CNT_W'(`LPRR_IR_HALF0 - 1);
      2'h1: limit = CNT_W'(`LPRR_IR_HALF1 - 1);
      2'h2: limit = CNT_W'(`LPRR_IR_HALF2 - 1);
      2'h3: limit = CNT_W'(`LPRR_IR_HALF3 - 1);
    endcase
  end

  // ==========================================================
  // toggle every half period; idle low so the led stays dark between measurements
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      ir_out <= 1'b0;
    end else if (!enable) begin
      cnt_r <= '0;
      ir_out <= 1'b0;
    end else if (cnt_r >= limit) begin // a change to a faster rate mid-period ends the half at once if the count is already past the new limit
      cnt_r <= '0;
      ir_out <= ~ir_out;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

endmodule : lprr_ir_gen
`default_nettype wire

/* verilog/lprr_regs.sv */
// result register bank with serial bus slave and infrared test signal control
`timescale 1ns/100ps
`default_nettype none
`include "lprr_map.svh"

// What this block does
// - ambient result is 16 bits: high byte at 85h, low byte at 86h.
// - ambient result bytes are read only; bus writes leave them unchanged.
// - proximity result is 16 bits: high byte at 87h, low byte at 88h.
// - proximity result bytes are read only; bus writes leave them unchanged.
// - frequency select sits in bits 1:0 at 89h, read/write; upper bits unused.
// - proximity measurement drives a square infrared test signal at selected rate.
// - select codes 0..3 give 3.125 MHz, 1.5625 MHz, 781.25 kHz, 390.625 kHz.
// - after reset the frequency select holds 2, i.e. 781.25 kHz.
// - host writes pointer without data, then reads; stop or repeated start both work.
// - pointer advances after each byte read, so high then low byte follow.
module lprr_regs
  import lprr_pkg::*;
#(
  parameter logic [6:0] BUS_ADDR = `LPRR_BUS_ADDR
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial bus pins, open drain data
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // finished measurements from the converters
  input wire lprr_meas_type amb_meas,
  input wire lprr_meas_type prox_meas,
  // proximity measurement in progress
  input wire logic prox_active,
  // infrared led drive
  output logic ir_drive
);

  lprr_state_type st_r;
  logic scl_q_r;
  logic sda_q_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic rw_r;
  logic first_r;
  logic mack_r;
  logic [7:0] ptr_r;
  logic [1:0] freq_r;
  logic [15:0] amb_r;
  logic [15:0] prox_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_hit;
  logic wr_strobe;
  logic ptr_load;
  logic rd_advance;
  logic [7:0] rd_byte;

  // ==========================================================
  // bus condition detection
  // pins are synchronous to clk, so one history flop per pin is enough
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
    end
  end

  assign scl_rise = scl_i & ~scl_q_r;
  assign scl_fall = ~scl_i & scl_q_r;
  assign start_det = scl_i & scl_q_r & sda_q_r & ~sda_i;
  assign stop_det = scl_i & scl_q_r & ~sda_q_r & sda_i;
  assign addr_hit = (shift_r[7:1] == BUS_ADDR);

  // strobes from the slave to the register bank
  assign wr_strobe = (st_r == LPRR_WRX) && scl_fall && (bit_cnt_r == 4'h8) && !first_r;
  assign ptr_load = (st_r == LPRR_WRX) && scl_fall && (bit_cnt_r == 4'h8) && first_r;
  assign rd_advance = (st_r == LPRR_RDATA) && scl_fall && (bit_cnt_r == 4'h7);

  // ==========================================================
  // read multiplexer; unmapped pointers read as zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (ptr_r)
      `LPRR_ADDR_AMB_HI: rd_byte = amb_r[15:8];
      `LPRR_ADDR_AMB_LO: rd_byte = amb_r[7:0];
      `LPRR_ADDR_PROX_HI: rd_byte = prox_r[15:8];
      `LPRR_ADDR_PROX_LO: rd_byte = prox_r[7:0];
      `LPRR_ADDR_FREQ: rd_byte = {6'h00, freq_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // serial slave state machine
  // data changes only while scl is low; ack and read bits launch on the falling edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= LPRR_IDLE;
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      mack_r <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      st_r <= LPRR_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      st_r <= LPRR_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (st_r)
        LPRR_IDLE: begin
          sda_oe <= 1'b0;
        end
        LPRR_ADDR: begin
          if (scl_rise && bit_cnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], sda_i};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            if (addr_hit) begin
              rw_r <= shift_r[0];
              first_r <= ~shift_r[0]; // a write always opens with the pointer byte
              sda_oe <= 1'b1;
              st_r <= LPRR_ACK;
            end else begin
              st_r <= LPRR_IDLE; // another slave is addressed
            end
          end
        end
        LPRR_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (rw_r) begin
              shift_r <= {rd_byte[6:0], 1'b0};
              sda_oe <= ~rd_byte[7];
              st_r <= LPRR_RDATA;
            end else begin
              sda_oe <= 1'b0;
              st_r <= LPRR_WRX;
            end
          end
        end
        LPRR_WRX: begin
          if (scl_rise && bit_cnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], sda_i};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            first_r <= 1'b0;
            sda_oe <= 1'b1; // every written byte is acknowledged, read-only ones too
            st_r <= LPRR_ACK;
          end
        end
        LPRR_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h7) begin
              sda_oe <= 1'b0; // hand the line to the host for its ack
              st_r <= LPRR_RACK;
            end else begin
              sda_oe <= ~shift_r[7];
              shift_r <= {shift_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        LPRR_RACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_i;
          end else if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (mack_r) begin
              shift_r <= {rd_byte[6:0], 1'b0}; // pointer already advanced
              sda_oe <= ~rd_byte[7];
              st_r <= LPRR_RDATA;
            end else begin
              st_r <= LPRR_IDLE; // host said no more; wait for stop or start
            end
          end
        end
      endcase
    end
  end

  // open drain: the pin is only ever pulled low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ==========================================================
  // register pointer; kept across stop so a later read finds it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_r <= 8'h00;
    end else if (ptr_load) begin
      ptr_r <= shift_r;
    end else if (wr_strobe || rd_advance) begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  // ==========================================================
  // frequency select; the only writable field here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freq_r <= `LPRR_FREQ_RST;
    end else if (wr_strobe && ptr_r == `LPRR_ADDR_FREQ) begin
      freq_r <= shift_r[`LPRR_FREQ_MSB:`LPRR_FREQ_LSB];
    end
  end

  // ==========================================================
  // result pairs: loaded only by the converters, never by the bus
  // both bytes load in one edge, so a high/low read pair between loads is coherent
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      amb_r <= 16'h0000;
    end else if (amb_meas.load) begin
      amb_r <= amb_meas.value;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prox_r <= 16'h0000;
    end else if (prox_meas.load) begin
      prox_r <= prox_meas.value;
    end
  end

  // ==========================================================
  // infrared test signal, rate from the frequency select field
  lprr_ir_gen #(
    .CNT_W(9)
  ) u_ir_gen (
    .clk(clk),
    .rst(rst),
    .enable(prox_active),
    .sel(freq_r),
    .ir_out(ir_drive)
  );

endmodule : lprr_regs
`default_nettype wire

/* dv/lprr_regs_sva.sv */
// port checker for the result register bank
`timescale 1ns/100ps
`default_nettype none
module lprr_regs_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus and ir pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic prox_active,
  input wire logic ir_drive
);
  logic [8:0] cnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // cycles the ir level has held; cleared on a toggle or while idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_r <= 9'h0;
    else if (!prox_active || ir_drive != $past(ir_drive)) cnt_r <= 9'h0;
    else cnt_r <= cnt_r + 9'h1;
  end
  // ==========================================================
  // bus pins: open drain, changes only just after an scl fall
  property p_sda_o; sda_o == 1'b0; endproperty
  a_sda_o: assert property (p_sda_o) else $error("data pin driven high");
  property p_oe_edge; $changed(sda_oe) |-> !$past(scl_i) && $past(scl_i, 2); endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("data drive moved off scl fall");
  property p_oe_stand; sda_oe && scl_i |=> sda_oe || !scl_i; endproperty
  a_oe_stand: assert property (p_oe_stand) else $error("data bit dropped while scl high");
  // ==========================================================
  // ir square wave: quiet when idle, half period between 32 and 256 clocks
  property p_ir_idle; !prox_active |=> !ir_drive; endproperty
  a_ir_idle: assert property (p_ir_idle) else $error("ir active while idle");
  property p_ir_first; $rose(prox_active) |-> !ir_drive [*8]; endproperty
  a_ir_first: assert property (p_ir_first) else $error("ir toggled too early");
  property p_ir_min; prox_active && $past(prox_active) && $changed(ir_drive) |-> cnt_r >= 9'd30; endproperty
  a_ir_min: assert property (p_ir_min) else $error("ir half period too short");
  property p_ir_max; prox_active |-> cnt_r <= 9'd257; endproperty
  a_ir_max: assert property (p_ir_max) else $error("ir half period too long");
  property p_rst; $fell(rst) |-> !sda_oe && !ir_drive; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule : lprr_regs_sva
bind lprr_regs lprr_regs_sva u_sva (.clk(clk), .rst(rst), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .prox_active(prox_active), .ir_drive(ir_drive));
`default_nettype wire

/* dv/lprr_host.sv */
// serial bus host model driving the register bank
`timescale 1ns/100ps
`default_nettype none
module lprr_host #(
  parameter logic [6:0] DEV = 7'h13
) (
  // clock
  input wire logic clk,
  // resolved data line, bus clock and host pull-down
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  logic [7:0] q;
  logic k;
  // bus idles released: scl driven high by the host, sda high through the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // ==========================================================
  // one bit: data moves only while scl is low, read at the end of high
  task automatic bit_x(input logic b, output logic r);
    sda_pull = ~b;
    wt(4);
    scl = 1'b1;
    wt(4);
    r = sda;
    scl = 1'b0;
    wt(2);
  endtask : bit_x
  task automatic start();
    sda_pull = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda_pull = 1'b1;
    wt(4);
    scl = 1'b0;
    wt(2);
  endtask : start
  task automatic stop();
    sda_pull = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(4);
    sda_pull = 1'b0;
    wt(4);
  endtask : stop
  // byte msb first, then the acknowledge slot
  task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], v[i]);
    bit_x(a, ack);
  endtask : byte_x
  // ==========================================================
  // pointer write without data, then two bytes read, stop or repeated start
  task automatic rd2(input logic [7:0] p, input logic rep, output logic [15:0] v, output logic nak);
    logic n1, n2, n3;
    start();
    byte_x({DEV, 1'b0}, 1'b1, q, n1);
    byte_x(p, 1'b1, q, n2);
    if (!rep) stop();
    start();
    byte_x({DEV, 1'b1}, 1'b1, q, n3);
    byte_x(8'hff, 1'b0, v[15:8], k);
    byte_x(8'hff, 1'b1, v[7:0], k);
    stop();
    nak = n1 | n2 | n3;
  endtask : rd2
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic nak);
    logic n1, n2, n3;
    start();
    byte_x({DEV, 1'b0}, 1'b1, q, n1);
    byte_x(p, 1'b1, q, n2);
    byte_x(d, 1'b1, q, n3);
    stop();
    nak = n1 | n2 | n3;
  endtask : wr
  // address phase only, for probing another slave address
  task automatic poke(input logic [6:0] a, output logic nak);
    start();
    byte_x({a, 1'b0}, 1'b1, q, nak);
    stop();
  endtask : poke
endmodule : lprr_host
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the result register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  import lprr_pkg::*;
  typedef struct packed {logic [7:0] ptr; logic rep; logic [15:0] exp;} lprr_row_type;
  logic clk, rst, scl, sda, sda_pull, sda_o, sda_oe, prox_active, ir_drive, nak;
  lprr_meas_type amb_meas, prox_meas;
  logic [15:0] v;
  int error_cnt, tests_run, n;
  // reads that cross byte and register boundaries
  // the last row runs past the frequency register into an unmapped pointer, which reads zero
  lprr_row_type rows [5] = '{'{8'h85, 1'b0, 16'ha55a}, '{8'h87, 1'b1, 16'h3cc3},
    '{8'h86, 1'b0, 16'h5a3c}, '{8'h88, 1'b1, 16'hc302}, '{8'h89, 1'b0, 16'h0200}};
  // open-drain line with pull-up
  assign sda = !((sda_oe && !sda_o) || sda_pull);
  lprr_regs u_dut (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .amb_meas(amb_meas), .prox_meas(prox_meas), .prox_active(prox_active), .ir_drive(ir_drive));
  lprr_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  // ==========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // bounded wait; a stuck wave ends the run
  task automatic wait_ir(input logic lvl);
    n = 0;
    while (ir_drive !== lvl && n < 600) begin
      @(negedge clk);
      n++;
    end
    if (n == 600) begin
      error_cnt++;
      end_sim();
    end
  endtask : wait_ir
  // high half of the wave is 32 clocks at code 0, doubling per step
  task automatic ir_half(input logic [1:0] c);
    u_host.wr(8'h89, {6'h0, c}, nak);
    prox_active = 1'b1;
    wait_ir(1'b1);
    wait_ir(1'b0);
    chk(16'(n), 16'(32 << c));
    prox_active = 1'b0;
    @(negedge clk);
  endtask : ir_half
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================================
  // main sequence
  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst = 1'b1;
    amb_meas = '0;
    prox_meas = '0;
    prox_active = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    u_host.rd2(8'h88, 1'b0, v, nak);
    chk(v, 16'h0002);
    amb_meas = {1'b1, 16'ha55a};
    prox_meas = {1'b1, 16'h3cc3};
    @(negedge clk);
    amb_meas = '0;
    prox_meas = '0;
    foreach (rows[i]) begin
      u_host.rd2(rows[i].ptr, rows[i].rep, v, nak);
      chk(v, rows[i].exp);
      chk({15'h0, nak}, 16'h0);
    end
    // writes to result bytes must not stick; freq keeps two bits only
    u_host.wr(8'h85, 8'hff, nak);
    chk({15'h0, nak}, 16'h0);
    u_host.wr(8'h88, 8'h00, nak);
    chk({15'h0, nak}, 16'h0);
    u_host.rd2(8'h85, 1'b1, v, nak);
    chk(v, 16'ha55a);
    u_host.rd2(8'h87, 1'b0, v, nak);
    chk(v, 16'h3cc3);
    u_host.wr(8'h89, 8'hff, nak);
    u_host.rd2(8'h88, 1'b0, v, nak);
    chk(v, 16'hc303);
    // back-to-back loads: the later one wins in both bytes
    amb_meas = {1'b1, 16'h1111};
    @(negedge clk);
    amb_meas = {1'b1, 16'h1234};
    @(negedge clk);
    amb_meas = '0;
    u_host.rd2(8'h85, 1'b0, v, nak);
    chk(v, 16'h1234);
    for (int c = 0; c < 4; c++) ir_half(2'(c));
    // a frame for another slave address is left unanswered
    u_host.poke(7'h12, nak);
    chk({15'h0, nak}, 16'h1);
    // second reset in mid-run restores the rate code
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    u_host.rd2(8'h88, 1'b0, v, nak);
    chk(v, 16'h0002);
    end_sim();
  end
endmodule : tb
`default_nettype wire
